//--- rtl/phy_regs_pkg.sv
/*
 * Constants, register map and field layout of the gigabit control and status register group.
 * Assumes a 5-bit management address and 16-bit register words on the device clock.
 */
// Notes on behaviour
// RULE_01: Decode test field codes 000 to 100.
// RULE_02: Controller never programs test codes 101-111.
// RULE_03: Manual role bit selects forced role negotiation.
// RULE_04: Forced role value ignored unless manual set.
// RULE_05: Forced value one master, zero slave.
// RULE_06: Gigabit duplex advertise bits reset from strap.
// RULE_07: Role fault bit latches high, else zero.
// RULE_08: Resolution bit: one master, resets to one.
// RULE_09: Local receiver status bit shows receiver health.
// RULE_10: Remote receiver status bit shows partner health.
// RULE_11: Partner gigabit duplex bits read-only, reset zero.
// RULE_12: Eight-bit idle error count, self-clearing, zero reset.
// RULE_13: Addresses 0x0B to 0x0E are reserved.
// RULE_14: Capability extension register reads fixed constants.
// RULE_15: Descrambler lock and link bits are live.
// RULE_16: Lock error, disconnect flags self-clear.
// RULE_17: Receive, transmit error flags self-clear.
// RULE_18: Stream delimiter error flags self-clear.
// RULE_19: Counters clear only on read or reset.
// RULE_20: Latched bit holds until read returns it.
package phy_regs_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [4:0] REG_GIG_CTRL  = 5'h09;
    localparam logic [4:0] REG_GIG_STAT  = 5'h0a;
    localparam logic [4:0] REG_RSV_LO    = 5'h0b;
    localparam logic [4:0] REG_RSV_HI    = 5'h0e;
    localparam logic [4:0] REG_CAP_EXT   = 5'h0f;
    localparam logic [4:0] REG_FE_STAT   = 5'h10;

    // Gigabit control fields
    localparam int CTRL_TEST_HI   = 15;
    localparam int CTRL_TEST_LO   = 13;
    localparam int CTRL_MANUAL    = 12;
    localparam int CTRL_FORCE_MS  = 11;
    localparam int CTRL_PORT_TYPE = 10;
    localparam int CTRL_ADV_FDX   = 9;
    localparam int CTRL_ADV_HDX   = 8;
    localparam int CTRL_RSV_HI    = 7;
    localparam logic [7:0] CTRL_RSV_RESET = 8'h00;

    // Gigabit status fields
    localparam int STAT_FAULT    = 15;
    localparam int STAT_RES_MS   = 14;
    localparam int STAT_LOC_RX   = 13;
    localparam int STAT_REM_RX   = 12;
    localparam int STAT_LP_FDX   = 11;
    localparam int STAT_LP_HDX   = 10;
    localparam int STAT_IDLE_HI  = 7;
    localparam logic [7:0] IDLE_CNT_RESET = 8'h00;
    localparam logic [7:0] IDLE_CNT_MAX   = 8'hff;

    // Fixed capability word: only gigabit copper full and half duplex
    localparam logic [15:0] CAP_EXT_VALUE = 16'h3000;

    // Fast-Ethernet status extension fields
    localparam int FE_DESCR_LOCK = 15;
    localparam int FE_LINK_UP    = 12;

    // Event flag indices, with the fast-Ethernet word bits of the six flags other than role fault
    localparam int NUM_FLAGS    = 7;
    localparam int FL_LOCK_ERR  = 0;
    localparam int FL_DISCONN   = 1;
    localparam int FL_RX_ERR    = 2;
    localparam int FL_TX_ERR    = 3;
    localparam int FL_SSD_ERR   = 4;
    localparam int FL_ESD_ERR   = 5;
    localparam int FL_ROLE_FLT  = 6;
    localparam int FE_BIT_LOCK  = 14;
    localparam int FE_BIT_DISC  = 13;
    localparam int FE_BIT_RX    = 11;
    localparam int FE_BIT_TX    = 10;
    localparam int FE_BIT_SSD   = 9;
    localparam int FE_BIT_ESD   = 8;

    // Strap settling: cycles after reset release before the strap is taken
    localparam logic [1:0] STRAP_SETTLE = 2'd3;

    localparam logic [15:0] ZERO_WORD = 16'h0000;

    typedef enum logic [2:0] {
        TEST_NORMAL,
        TEST_WAVEFORM,
        TEST_JITTER_MASTER,
        TEST_JITTER_SLAVE,
        TEST_DISTORTION,
        TEST_UNDEFINED
    } tx_test_t;

endpackage

//--- rtl/flag_if.sv
/*
 * Carrier for sticky event flags between the register bank and its flag store.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface flag_if #(
    parameter int N = 7
);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] flags;

    modport owner (input set, input clr, output flags);
    modport user  (output set, output clr, input flags);
endinterface

//--- rtl/event_flags.sv
/*
 * Sticky event flags, cleared on read, set winning over clear.
 * Assumes set and clear arrive as one-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
module event_flags
    import phy_regs_pkg::*;
#(
    parameter int N = NUM_FLAGS
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic soft_rst,
    flag_if.owner     fl
);
    logic [N-1:0] flags_r;
    logic [N-1:0] flags_nxt;

    // Set wins over clear; software reset clears all
    assign flags_nxt = soft_rst ? '0 : (fl.set | (flags_r & ~fl.clr)); // [RULE_19] [RULE_20]

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign fl.flags = flags_r;
endmodule

//--- rtl/gigabit_phy_status_control_regs.sv
/*
 * Gigabit control and status register group with fast-Ethernet status extension.
 * Assumes a management controller issuing one-cycle read and write strobes on clk_sys,
 * PHY core status and event pulses on clk_sys, and an asynchronous duplex strap pin.
 */
`timescale 1ns/1ps
module gigabit_phy_status_control_regs
    import phy_regs_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              soft_rst,
    input  wire logic [1:0]        hardware_config_strap,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   reg_rvalid,
    input  wire logic              role_fault_evt,
    input  wire logic              role_resolve_evt,
    input  wire logic              role_resolved_master,
    input  wire logic              local_rx_ok,
    input  wire logic              remote_rx_ok,
    input  wire logic              lp_ability_load,
    input  wire logic              lp_gig_fdx,
    input  wire logic              lp_gig_hdx,
    input  wire logic              idle_err_evt,
    input  wire logic              fe_descrambler_locked,
    input  wire logic              fe_link_up,
    input  wire logic              fe_lock_err_evt,
    input  wire logic              fe_disconnect_evt,
    input  wire logic              fe_rx_err_evt,
    input  wire logic              fe_tx_err_evt,
    input  wire logic              fe_ssd_err_evt,
    input  wire logic              fe_esd_err_evt,
    output tx_test_t               tx_test_mode,
    output logic                   role_manual,
    output logic                   role_force_master,
    output logic                   port_multi,
    output logic                   adv_gig_fdx,
    output logic                   adv_gig_hdx
);

    function automatic tx_test_t decode_test(input logic [2:0] code);
        tx_test_t m;
        case (code)
            3'h0: begin
                m = TEST_NORMAL;
            end
            3'h1: begin
                m = TEST_WAVEFORM;
            end
            3'h2: begin
                m = TEST_JITTER_MASTER;
            end
            3'h3: begin
                m = TEST_JITTER_SLAVE;
            end
            3'h4: begin
                m = TEST_DISTORTION;
            end
            default: begin
                m = TEST_UNDEFINED;
            end
        endcase
        return m;
    endfunction

    // Strap synchroniser and load sequencing
    logic [1:0]  strap_s1_r;
    logic [1:0]  strap_s2_r;
    logic [1:0]  settle_r;
    logic        strap_done_r;
    logic        strap_take;

    // Control register fields
    logic [2:0]  test_code_r;
    logic        manual_r;
    logic        force_ms_r;
    logic        port_type_r;
    logic        adv_fdx_r;
    logic        adv_hdx_r;
    logic [7:0]  ctrl_rsv_r;

    // Status state
    logic        res_master_r;
    logic        lp_fdx_r;
    logic        lp_hdx_r;
    logic [7:0]  idle_cnt_r;
    logic [7:0]  idle_cnt_nxt;

    // Read path
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic              rvalid_r;

    // Address decode
    wire  sel_ctrl = (reg_addr == REG_GIG_CTRL);
    wire  sel_stat = (reg_addr == REG_GIG_STAT);
    wire  sel_rsv  = (reg_addr >= REG_RSV_LO) && (reg_addr <= REG_RSV_HI); // [RULE_13]
    wire  sel_cap  = (reg_addr == REG_CAP_EXT);
    wire  sel_fe   = (reg_addr == REG_FE_STAT);
    wire  wr_ctrl  = reg_wr && sel_ctrl;
    wire  rd_stat  = reg_rd && sel_stat;
    wire  rd_fe    = reg_rd && sel_fe;

    flag_if #(.N(NUM_FLAGS)) fl ();

    event_flags #(
        .N (NUM_FLAGS)
    ) u_flags (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .soft_rst (soft_rst),
        .fl       (fl)
    );

    // Event pulses into sticky flags
    assign fl.set[FL_LOCK_ERR] = fe_lock_err_evt;   // [RULE_16]
    assign fl.set[FL_DISCONN]  = fe_disconnect_evt; // [RULE_16]
    assign fl.set[FL_RX_ERR]   = fe_rx_err_evt;     // [RULE_17]
    assign fl.set[FL_TX_ERR]   = fe_tx_err_evt;     // [RULE_17]
    assign fl.set[FL_SSD_ERR]  = fe_ssd_err_evt;    // [RULE_18]
    assign fl.set[FL_ESD_ERR]  = fe_esd_err_evt;    // [RULE_18]
    assign fl.set[FL_ROLE_FLT] = role_fault_evt;    // [RULE_07]

    // Reads of the owning register clear the flags
    assign fl.clr[FL_LOCK_ERR] = rd_fe; // [RULE_19]
    assign fl.clr[FL_DISCONN]  = rd_fe;
    assign fl.clr[FL_RX_ERR]   = rd_fe;
    assign fl.clr[FL_TX_ERR]   = rd_fe;
    assign fl.clr[FL_SSD_ERR]  = rd_fe;
    assign fl.clr[FL_ESD_ERR]  = rd_fe;
    assign fl.clr[FL_ROLE_FLT] = rd_stat; // [RULE_20]

    // Strap is taken once, after the synchroniser has settled
    assign strap_take = !strap_done_r && (settle_r == STRAP_SETTLE);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            strap_s1_r <= 2'h0;
            strap_s2_r <= 2'h0;
        end else begin
            strap_s1_r <= hardware_config_strap;
            strap_s2_r <= strap_s1_r;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            settle_r     <= 2'h0;
            strap_done_r <= 1'b0;
        end else begin
            if (settle_r != STRAP_SETTLE) begin
                settle_r <= settle_r + 2'h1;
            end
            if (strap_take) begin
                strap_done_r <= 1'b1;
            end
        end
    end

    // Test mode, role and port type fields
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            test_code_r <= 3'h0;
            manual_r    <= 1'b0;
            force_ms_r  <= 1'b0;
            port_type_r <= 1'b0;
            ctrl_rsv_r  <= CTRL_RSV_RESET;
        end else if (soft_rst) begin
            test_code_r <= 3'h0;
            manual_r    <= 1'b0;
            force_ms_r  <= 1'b0;
            port_type_r <= 1'b0;
            ctrl_rsv_r  <= CTRL_RSV_RESET;
        end else if (wr_ctrl) begin
            test_code_r <= reg_wdata[CTRL_TEST_HI:CTRL_TEST_LO];
            manual_r    <= reg_wdata[CTRL_MANUAL];
            force_ms_r  <= reg_wdata[CTRL_FORCE_MS];
            port_type_r <= reg_wdata[CTRL_PORT_TYPE];
            ctrl_rsv_r  <= reg_wdata[CTRL_RSV_HI:0];
        end
    end

    // Duplex advertise bits default from the strap; a write in the strap load cycle wins, an earlier write is overwritten
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            adv_fdx_r <= 1'b0;
            adv_hdx_r <= 1'b0;
        end else if (soft_rst) begin
            adv_fdx_r <= strap_s2_r[1]; // [RULE_06]
            adv_hdx_r <= strap_s2_r[0];
        end else if (wr_ctrl) begin
            adv_fdx_r <= reg_wdata[CTRL_ADV_FDX];
            adv_hdx_r <= reg_wdata[CTRL_ADV_HDX];
        end else if (strap_take) begin
            adv_fdx_r <= strap_s2_r[1]; // [RULE_06]
            adv_hdx_r <= strap_s2_r[0];
        end
    end

    // Role resolution and partner ability
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            res_master_r <= 1'b1;
            lp_fdx_r     <= 1'b0;
            lp_hdx_r     <= 1'b0;
        end else if (soft_rst) begin
            res_master_r <= 1'b1;
            lp_fdx_r     <= 1'b0;
            lp_hdx_r     <= 1'b0;
        end else begin
            if (role_resolve_evt) begin
                res_master_r <= role_resolved_master; // [RULE_08]
            end
            if (lp_ability_load) begin
                lp_fdx_r <= lp_gig_fdx; // [RULE_11]
                lp_hdx_r <= lp_gig_hdx;
            end
        end
    end

    // Idle error count: saturates, clears on read, an error in the read cycle counts as one
    always_comb begin
        idle_cnt_nxt = idle_cnt_r;
        if (soft_rst) begin
            idle_cnt_nxt = IDLE_CNT_RESET; // [RULE_19]
        end else if (rd_stat) begin
            idle_cnt_nxt = idle_err_evt ? (IDLE_CNT_RESET + 8'h01) : IDLE_CNT_RESET; // [RULE_12] [RULE_19]
        end else if (idle_err_evt && (idle_cnt_r != IDLE_CNT_MAX)) begin
            idle_cnt_nxt = idle_cnt_r + 8'h01; // [RULE_12]
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            idle_cnt_r <= IDLE_CNT_RESET;
        end else begin
            idle_cnt_r <= idle_cnt_nxt;
        end
    end

    // Register words
    wire [DATA_W-1:0] ctrl_word = {test_code_r, manual_r, force_ms_r, port_type_r,
                                   adv_fdx_r, adv_hdx_r, ctrl_rsv_r};

    wire [DATA_W-1:0] stat_word = {fl.flags[FL_ROLE_FLT], // [RULE_07]
                                   res_master_r,          // [RULE_08]
                                   local_rx_ok,           // [RULE_09]
                                   remote_rx_ok,          // [RULE_10]
                                   lp_fdx_r,              // [RULE_11]
                                   lp_hdx_r,
                                   2'b00,
                                   idle_cnt_r};           // [RULE_12]

    wire [DATA_W-1:0] fe_word = {fe_descrambler_locked,   // [RULE_15]
                                 fl.flags[FL_LOCK_ERR],   // [RULE_16]
                                 fl.flags[FL_DISCONN],
                                 fe_link_up,              // [RULE_15]
                                 fl.flags[FL_RX_ERR],     // [RULE_17]
                                 fl.flags[FL_TX_ERR],
                                 fl.flags[FL_SSD_ERR],    // [RULE_18]
                                 fl.flags[FL_ESD_ERR],
                                 8'h00};

    // Read multiplexer; reserved and unmapped addresses read zero
    always_comb begin
        rdata_nxt = ZERO_WORD;
        if (sel_ctrl) begin
            rdata_nxt = ctrl_word;
        end else if (sel_stat) begin
            rdata_nxt = stat_word;
        end else if (sel_rsv) begin
            rdata_nxt = ZERO_WORD; // [RULE_13]
        end else if (sel_cap) begin
            rdata_nxt = CAP_EXT_VALUE; // [RULE_14]
        end else if (sel_fe) begin
            rdata_nxt = fe_word;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r  <= ZERO_WORD;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata  = rdata_r;
    assign reg_rvalid = rvalid_r;

    // Control outputs to the PHY core
    assign tx_test_mode      = decode_test(test_code_r); // [RULE_01]
    assign role_manual       = manual_r;                 // [RULE_03]
    assign role_force_master = manual_r & force_ms_r;    // [RULE_04] [RULE_05]
    assign port_multi        = port_type_r;
    assign adv_gig_fdx       = adv_fdx_r;
    assign adv_gig_hdx       = adv_hdx_r;

endmodule

//--- dv/mgmt_ctrl_model.sv
/* Management controller model: one-cycle read and write strobes.
   Assumes the register port of the group and clk_sys; drives at falling edges. */
`timescale 1ns/1ps
module mgmt_ctrl_model
    import phy_regs_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              reg_rvalid,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic                   reg_wr,
    output logic                   reg_rd,
    output logic      [DATA_W-1:0] reg_wdata
);
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // Single write, data inverted once released
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == REG_GIG_CTRL && v[15:13] > 3'h4) begin
            v[15:13] = 3'h0;
        end
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_wdata = ~v;
    endtask
    // Single read, answer taken one cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

//--- dv/gigabit_phy_status_control_regs_asserts.sv
/* Port checker for the gigabit register group.
   Assumes clk_sys and active-high sys_rst of the top module. */
`timescale 1ns/1ps
module gigabit_phy_status_control_regs_asserts
    import phy_regs_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    input wire logic              soft_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic              local_rx_ok,
    input wire logic              remote_rx_ok,
    input wire logic              idle_err_evt,
    input wire logic              fe_descrambler_locked,
    input wire logic              fe_link_up,
    input wire logic              fe_rx_err_evt,
    input wire tx_test_t          tx_test_mode,
    input wire logic              role_manual,
    input wire logic              role_force_master,
    input wire logic              adv_gig_fdx,
    input wire logic              adv_gig_hdx
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire wr_ctl = reg_wr && !soft_rst && reg_addr == REG_GIG_CTRL;
    wire rd_st  = reg_rd && reg_addr == REG_GIG_STAT;
    wire rd_fe  = reg_rd && reg_addr == REG_FE_STAT;
    wire rd_rsv = reg_rd && reg_addr >= 5'h0b && reg_addr <= 5'h0e;

    chk_rsv_zero: assert property (rd_rsv |=> reg_rvalid && reg_rdata == 16'h0000)
        else $error("reserved read not zero");
    chk_cap_const: assert property (reg_rd && reg_addr == 5'h0f |=> reg_rdata == 16'h3000)
        else $error("capability word wrong");
    chk_test_decode: assert property (wr_ctl && reg_wdata[15:13] <= 3'h4
        |=> tx_test_mode == $past(reg_wdata[15:13])) else $error("test mode decode wrong");
    chk_manual_bit: assert property (wr_ctl |=> role_manual == $past(reg_wdata[12]))
        else $error("manual role bit wrong");
    chk_force_gate: assert property (!role_manual |-> !role_force_master)
        else $error("forced role used without manual");
    chk_force_value: assert property (wr_ctl |=> role_force_master == ($past(reg_wdata[12]) && $past(reg_wdata[11])))
        else $error("forced role value wrong");
    chk_adv_bits: assert property (wr_ctl |=> {adv_gig_fdx, adv_gig_hdx} == $past(reg_wdata[9:8]))
        else $error("advertise bits wrong");
    chk_rx_live: assert property (rd_st && !soft_rst |=> reg_rdata[13] == $past(local_rx_ok)
        && reg_rdata[12] == $past(remote_rx_ok)) else $error("receiver status not live");
    chk_fe_live: assert property (rd_fe |=> reg_rdata[15] == $past(fe_descrambler_locked)
        && reg_rdata[12] == $past(fe_link_up)) else $error("fast status not live");
    chk_rx_err_flag: assert property (fe_rx_err_evt && !soft_rst ##1 rd_fe |=> reg_rdata[11])
        else $error("receive error flag lost");
    chk_idle_clear: assert property (rd_st && !idle_err_evt ##1 !idle_err_evt ##1 rd_st |=> reg_rdata[7:0] == 8'h00)
        else $error("idle count not cleared by read");

    cov_ctrl_write: cover property (wr_ctl);
    cov_fault_read: cover property (rd_st ##1 reg_rdata[15]);
    cov_fe_flag: cover property (rd_fe ##1 reg_rdata[11]);
endmodule

bind gigabit_phy_status_control_regs gigabit_phy_status_control_regs_asserts chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .local_rx_ok(local_rx_ok), .remote_rx_ok(remote_rx_ok),
    .idle_err_evt(idle_err_evt), .fe_descrambler_locked(fe_descrambler_locked),
    .fe_link_up(fe_link_up), .fe_rx_err_evt(fe_rx_err_evt), .tx_test_mode(tx_test_mode),
    .role_manual(role_manual), .role_force_master(role_force_master),
    .adv_gig_fdx(adv_gig_fdx), .adv_gig_hdx(adv_gig_hdx));

//--- dv/gigabit_phy_status_control_regs_bench.sv
/* Self-checking bench for the gigabit register group.
   Assumes the management model and checker files are compiled before it. */
`timescale 1ns/1ps
module gigabit_phy_status_control_regs_bench;
    import phy_regs_pkg::*;
    logic        clk_sys;
    logic        sys_rst;
    logic [1:0]  strap;
    logic [10:0] ev;
    logic        res_master, loc_ok, rem_ok, lp_fdx, lp_hdx, descr, link;
    logic [4:0]  reg_addr;
    logic        reg_wr, reg_rd, reg_rvalid;
    logic [15:0] reg_wdata, reg_rdata;
    tx_test_t    tx_test_mode;
    logic        role_manual, role_force_master, port_multi, adv_gig_fdx, adv_gig_hdx;
    int          errors, checked, cycles;

    gigabit_phy_status_control_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(ev[10]),
        .hardware_config_strap(strap), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .role_fault_evt(ev[6]), .role_resolve_evt(ev[8]), .role_resolved_master(res_master),
        .local_rx_ok(loc_ok), .remote_rx_ok(rem_ok), .lp_ability_load(ev[9]), .lp_gig_fdx(lp_fdx),
        .lp_gig_hdx(lp_hdx), .idle_err_evt(ev[7]), .fe_descrambler_locked(descr), .fe_link_up(link),
        .fe_lock_err_evt(ev[0]), .fe_disconnect_evt(ev[1]), .fe_rx_err_evt(ev[2]),
        .fe_tx_err_evt(ev[3]), .fe_ssd_err_evt(ev[4]), .fe_esd_err_evt(ev[5]),
        .tx_test_mode(tx_test_mode), .role_manual(role_manual), .role_force_master(role_force_master),
        .port_multi(port_multi), .adv_gig_fdx(adv_gig_fdx), .adv_gig_hdx(adv_gig_hdx));
    mgmt_ctrl_model mgmt (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic [2:0] got, input logic [2:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: field %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        mgmt.rd(a, d, ok);
        chk_b({2'b00, ok}, 3'b001);
        chk_w(d, exp);
    endtask
    // One-cycle pulse on an event input
    task automatic fire(input int i);
        @(negedge clk_sys);
        ev[i] = 1'b1;
        @(negedge clk_sys);
        ev[i] = 1'b0;
    endtask

    task automatic t_defaults;
        rdchk(REG_GIG_CTRL, 16'h0200);
        rdchk(REG_GIG_STAT, 16'h4000);
        rdchk(REG_CAP_EXT, 16'h3000);
        rdchk(REG_FE_STAT, 16'h0000);
        $display("defaults done");
    endtask
    task automatic t_ctrl;
        for (int c = 0; c < 5; c++) begin
            mgmt.wr(REG_GIG_CTRL, {c[2:0], 13'h0ea5});
            chk_b(tx_test_mode, c[2:0]);
            chk_b({role_manual, role_force_master, port_multi}, 3'b001);
            chk_b({1'b0, adv_gig_fdx, adv_gig_hdx}, 3'b010);
            rdchk(REG_GIG_CTRL, {c[2:0], 13'h0ea5});
        end
        mgmt.wr(REG_GIG_CTRL, 16'h1800);
        chk_b({1'b0, role_manual, role_force_master}, 3'b011);
        mgmt.wr(REG_GIG_CTRL, 16'h1000);
        chk_b({1'b0, role_manual, role_force_master}, 3'b010);
        for (int a = 11; a < 15; a++) begin
            mgmt.wr(a[4:0], 16'hffff);
            rdchk(a[4:0], 16'h0000);
        end
        rdchk(REG_GIG_CTRL, 16'h1000);
        $display("control done");
    endtask
    task automatic t_status;
        @(negedge clk_sys);
        {loc_ok, rem_ok, res_master, lp_fdx, lp_hdx} = 5'b11010;
        fire(8);
        fire(9);
        fire(6);
        repeat (3) fire(7);
        rdchk(REG_GIG_STAT, 16'hb803);
        rem_ok = 1'b0;
        rdchk(REG_GIG_STAT, 16'h2800);
        rdchk(REG_GIG_STAT, 16'h2800);
        $display("status done");
    endtask
    task automatic t_fast;
        int pos[6] = '{14, 13, 11, 10, 9, 8};
        @(negedge clk_sys);
        {descr, link} = 2'b11;
        for (int i = 0; i < 6; i++) begin
            fire(i);
            rdchk(REG_FE_STAT, 16'h9000 | (16'h0001 << pos[i]));
        end
        link = 1'b0;
        rdchk(REG_FE_STAT, 16'h8000);
        $display("fast status done");
    endtask
    task automatic t_soft;
        repeat (2) fire(7);
        fire(10);
        rdchk(REG_GIG_STAT, 16'h6000);
        rdchk(REG_GIG_CTRL, 16'h0200);
        $display("soft reset done");
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        errors = 0;
        checked = 0;
        cycles = 0;
        sys_rst = 1'b1;
        strap = 2'b10;
        ev = 11'h000;
        {res_master, loc_ok, rem_ok, lp_fdx, lp_hdx, descr, link} = 7'h00;
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        t_defaults();
        t_ctrl();
        t_status();
        t_fast();
        t_soft();
        give_verdict();
    end
endmodule
